/* File: atc_map.svh */
// Register offsets, field positions and reset values of the aperture
// translation control block. Assumes byte addresses in configuration space.
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// Configuration space offsets
`define ATC_OFS_PORT_STATUS  8'hA8
`define ATC_OFS_AP_BASE      8'h10
`define ATC_OFS_CTRL         8'hB0
`define ATC_OFS_APERTURE_SIZE_SELECT       8'hB4

// Field positions
`define ATC_BIT_TLB_EN       7
`define ATC_BIT_OVERRIDE     0
`define ATC_BIT_APERTURE_SIZE_BIT       3
`define ATC_BIT_BASE25       25
`define ATC_BIT_RATE_TOP     2

// Reset values
`define ATC_RST_CTRL         32'h0000_0000
`define ATC_RST_APERTURE_SIZE_SELECT       8'h00
`define ATC_RST_RATE         3'h0
`define ATC_RST_BASE25       1'b0

`endif

/* File: atc_pkg.sv */
// Types shared by the aperture translation control block.
// Assumes the offsets and reset values of atc_map.svh.
package atc_pkg;

  // One configuration space access
  typedef struct packed {
    logic        valid;  // Access strobe
    logic        write;  // 1 = write, 0 = read
    logic [7:0]  addr;   // Dword aligned byte address
    logic [3:0]  be;     // Byte enables
    logic [31:0] wdata;  // Write data
  } atc_cfg_type;

  // Lookup engine states
  typedef enum logic [1:0] {
    ATC_IDLE,
    ATC_HIT,
    ATC_FETCH,
    ATC_DONE
  } atc_state_type;

endpackage

/* File: atc_tlb_mem.sv */
// Entry store of the translation lookaside buffer: one write port and one
// read port whose data leave through a register. Assumes a single clock.
module atc_tlb_mem
  import atc_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter int WIDTH   = 33
)
(
  // Clock
  input  wire logic                       clk_i,
  // Write port
  input  wire logic                       we_i,
  input  wire logic [$clog2(ENTRIES)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]           wdata_i,
  // Read port, data one cycle after the address
  input  wire logic [$clog2(ENTRIES)-1:0] raddr_i,
  output logic      [WIDTH-1:0]           rdata_o
);

  // Storage array
  logic [WIDTH-1:0] mem_r [ENTRIES];

  // Write and registered read
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end

endmodule // atc_tlb_mem

/* File: atc_top.sv */
// Aperture translation control: configuration registers, translation
// buffer enable and flush, write buffer flush, fast rate override and
// aperture size gating. Assumes a memory side that answers table fetches.
`include "atc_map.svh"

// Operation
// - Enable low clears every buffer valid flag
// - Disabled: always fetch, never store entries
// - Enabled: look up and cache translations
// - Invalid fetched entry still replaces LRU entry
// - Any enable bit write flushes write buffer
// - Enable change mid access stays safe
// - Override hides top rate bit on reads
// - Size bit 0: base bit 25 is zero
// - Size bit 1: base bit 25 read/write
// - Aperture size register resets to zero
// - Control register resets to all zeros
// - Override set: top rate bit not written
module atc_top
  import atc_pkg::*;
#(
  parameter int ENTRIES = 4,   // Buffer entries, power of two
  parameter int TAG_W   = 20,  // Aperture page number width
  parameter int DATA_W  = 32   // Translated entry width
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Configuration space access
  input  atc_cfg_type            cfg_i,
  output logic      [31:0]       cfg_rdata_o,
  // Translation requests
  input  wire logic              lk_valid_i,
  input  wire logic [TAG_W-1:0]  lk_page_i,
  output logic                   lk_ready_o,
  output logic                   rsp_valid_o,
  output logic      [DATA_W-1:0] rsp_data_o,
  output logic                   rsp_entry_ok_o,
  // Table fetches from main memory
  output logic                   fetch_req_o,
  output logic      [TAG_W-1:0]  fetch_page_o,
  input  wire logic              fetch_ack_i,
  input  wire logic [DATA_W-1:0] fetch_data_i,
  input  wire logic              fetch_entry_ok_i,
  // Control outputs to the rest of the hub
  output logic                   gwb_flush_o,
  output logic                   tlb_enable_o,
  output logic                   fast_rate_override_o,
  output logic      [2:0]        data_rate_o,
  output logic                   ap_base_b25_o
);

  localparam int IW = $clog2(ENTRIES);
  localparam int MW = DATA_W + 1;
  // Reset words, so single bits are picked by position, not by shift
  localparam logic [31:0] RST_CTRL = `ATC_RST_CTRL;
  localparam logic [7:0]  RST_SIZE = `ATC_RST_APERTURE_SIZE_SELECT;

  // Elaboration check on the buffer shape
  if (ENTRIES < 2 || (1 << IW) != ENTRIES || TAG_W < 1 || DATA_W < 1)
  begin : g_bad_param
    $error("atc_top: ENTRIES must be a power of two of at least 2");
  end

  // Byte lane merge of a write into a 32 bit word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Register state
  logic        tlb_en_r, tlb_en_nxt;      // Translation buffer enable
  logic        ovr_r, ovr_nxt;            // Fast rate override
  logic        aperture_size_bit_r, aperture_size_bit_nxt;      // Aperture size bit
  logic [2:0]  rate_r, rate_nxt;          // Data rate field
  logic        b25_r, b25_nxt;            // Aperture base bit 25
  logic        flush_r, flush_nxt;        // Write buffer flush pulse
  logic [31:0] rdata_r, rdata_nxt;        // Read data
  logic [31:0] ctrl_v, size_v, rate_v, base_v; // Read views
  logic [31:0] wr_v;                      // Merged write value
  logic        wr_en;                     // Register write strobe

  // Read views of each register
  always_comb
  begin
    ctrl_v = '0;
    size_v = '0;
    rate_v = '0;
    base_v = '0;
    ctrl_v[`ATC_BIT_TLB_EN]   = tlb_en_r;
    ctrl_v[`ATC_BIT_OVERRIDE] = ovr_r;
    size_v[`ATC_BIT_APERTURE_SIZE_BIT]   = aperture_size_bit_r;
    rate_v[2:0]               = rate_r;
    if (ovr_r)
    begin
      rate_v[`ATC_BIT_RATE_TOP] = 1'b0;
    end
    base_v[`ATC_BIT_BASE25]   = b25_r & aperture_size_bit_r;
  end

  // Next values of the configuration registers
  always_comb
  begin
    tlb_en_nxt = tlb_en_r;
    ovr_nxt    = ovr_r;
    aperture_size_bit_nxt = aperture_size_bit_r;
    rate_nxt   = rate_r;
    b25_nxt    = b25_r;
    flush_nxt  = 1'b0;
    rdata_nxt  = rdata_r;
    wr_en      = cfg_i.valid & cfg_i.write;
    wr_v       = '0;
    if (cfg_i.valid)
    begin
      case (cfg_i.addr)
        `ATC_OFS_CTRL:
        begin
          wr_v = lane_merge(ctrl_v, cfg_i.wdata, cfg_i.be);
          if (wr_en)
          begin
            tlb_en_nxt = wr_v[`ATC_BIT_TLB_EN];
            ovr_nxt    = wr_v[`ATC_BIT_OVERRIDE];
            flush_nxt  = cfg_i.be[`ATC_BIT_TLB_EN / 8];
          end
          rdata_nxt = ctrl_v;
        end
        `ATC_OFS_APERTURE_SIZE_SELECT:
        begin
          wr_v = lane_merge(size_v, cfg_i.wdata, cfg_i.be);
          if (wr_en)
          begin
            aperture_size_bit_nxt = wr_v[`ATC_BIT_APERTURE_SIZE_BIT];
          end
          rdata_nxt = size_v;
        end
        `ATC_OFS_PORT_STATUS:
        begin
          wr_v = lane_merge({29'h0, rate_r}, cfg_i.wdata, cfg_i.be);
          if (wr_en)
          begin
            rate_nxt[1:0] = wr_v[1:0];
            if (!ovr_r)
            begin
              rate_nxt[`ATC_BIT_RATE_TOP] = wr_v[`ATC_BIT_RATE_TOP];
            end
          end
          rdata_nxt = rate_v;
        end
        `ATC_OFS_AP_BASE:
        begin
          wr_v = lane_merge(base_v, cfg_i.wdata, cfg_i.be);
          if (wr_en && aperture_size_bit_r)
          begin
            b25_nxt = wr_v[`ATC_BIT_BASE25];
          end
          rdata_nxt = base_v;
        end
        // Unmapped offsets read zero
        default:
        begin
          rdata_nxt = '0;
        end
      endcase
    end
    if (!aperture_size_bit_nxt)
    begin
      b25_nxt = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tlb_en_r <= RST_CTRL[`ATC_BIT_TLB_EN];
      ovr_r    <= RST_CTRL[`ATC_BIT_OVERRIDE];
      aperture_size_bit_r <= RST_SIZE[`ATC_BIT_APERTURE_SIZE_BIT];
      rate_r   <= `ATC_RST_RATE;
      b25_r    <= `ATC_RST_BASE25;
      flush_r  <= 1'b0;
      rdata_r  <= '0;
    end
    else
    begin
      tlb_en_r <= tlb_en_nxt;
      ovr_r    <= ovr_nxt;
      aperture_size_bit_r <= aperture_size_bit_nxt;
      rate_r   <= rate_nxt;
      b25_r    <= b25_nxt;
      flush_r  <= flush_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Lookup engine state
  atc_state_type            st_r, st_nxt;       // Engine state
  logic [ENTRIES-1:0]       vld_r, vld_nxt;     // Entry valid flags
  logic [TAG_W-1:0]         tag_r [ENTRIES];    // Entry page tags
  logic [TAG_W-1:0]         tag_nxt [ENTRIES];
  logic [IW-1:0]            age_r [ENTRIES];    // Use order, max = oldest
  logic [IW-1:0]            age_nxt [ENTRIES];
  logic [TAG_W-1:0]         page_r, page_nxt;   // Page being served
  logic [DATA_W-1:0]        dat_r, dat_nxt;     // Answer data
  logic                     ok_r, ok_nxt;       // Answer entry valid
  logic                     hit;                // Lookup hit
  logic [IW-1:0]            hit_idx, vic_idx;   // Hit and victim slots
  logic                     mem_we;             // Store fetched entry
  logic [MW-1:0]            mem_rdata;          // Stored entry

  // Tag compare and victim choice
  always_comb
  begin
    hit     = 1'b0;
    hit_idx = '0;
    vic_idx = '0;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (tlb_en_r && vld_r[i] && tag_r[i] == lk_page_i)
      begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
      if (age_r[i] == IW'(ENTRIES - 1))
      begin
        vic_idx = IW'(i);
      end
    end
  end

  // Entry store
  atc_tlb_mem #(
    .ENTRIES (ENTRIES),
    .WIDTH   (MW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (vic_idx),
    .wdata_i ({fetch_entry_ok_i, fetch_data_i}),
    .raddr_i (hit_idx),
    .rdata_o (mem_rdata)
  );

  // Next values of the lookup engine
  always_comb
  begin
    st_nxt   = st_r;
    vld_nxt  = vld_r;
    tag_nxt  = tag_r;
    age_nxt  = age_r;
    page_nxt = page_r;
    dat_nxt  = dat_r;
    ok_nxt   = ok_r;
    mem_we   = 1'b0;
    case (st_r)
      ATC_IDLE:
      begin
        if (lk_valid_i)
        begin
          page_nxt = lk_page_i;
          st_nxt   = hit ? ATC_HIT : ATC_FETCH;
          if (hit)
          begin
            for (int i = 0; i < ENTRIES; i++)
            begin
              if (age_r[i] < age_r[hit_idx])
              begin
                age_nxt[i] = age_r[i] + IW'(1);
              end
            end
            age_nxt[hit_idx] = '0;
          end
        end
      end
      ATC_HIT:
      begin
        dat_nxt = mem_rdata[DATA_W-1:0];
        ok_nxt  = mem_rdata[DATA_W];
        st_nxt  = ATC_DONE;
      end
      ATC_FETCH:
      begin
        if (fetch_ack_i)
        begin
          dat_nxt = fetch_data_i;
          ok_nxt  = fetch_entry_ok_i;
          st_nxt  = ATC_DONE;
          if (tlb_en_r)
          begin
            mem_we            = 1'b1;
            vld_nxt[vic_idx]  = 1'b1;
            tag_nxt[vic_idx]  = page_r;
            for (int i = 0; i < ENTRIES; i++)
            begin
              age_nxt[i] = age_r[i] + IW'(1);
            end
            age_nxt[vic_idx]  = '0;
          end
        end
      end
      ATC_DONE:
      begin
        st_nxt = ATC_IDLE;
      end
      default:
      begin
        st_nxt = ATC_IDLE;
      end
    endcase
    if (!tlb_en_r)
    begin
      vld_nxt = '0;
    end
  end

  // Lookup engine registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r   <= ATC_IDLE;
      vld_r  <= '0;
      page_r <= '0;
      dat_r  <= '0;
      ok_r   <= 1'b0;
      for (int i = 0; i < ENTRIES; i++)
      begin
        tag_r[i] <= '0;
        age_r[i] <= IW'(i);
      end
    end
    else
    begin
      st_r   <= st_nxt;
      vld_r  <= vld_nxt;
      page_r <= page_nxt;
      dat_r  <= dat_nxt;
      ok_r   <= ok_nxt;
      tag_r  <= tag_nxt;
      age_r  <= age_nxt;
    end
  end

  // Outputs
  assign cfg_rdata_o          = rdata_r;
  assign lk_ready_o           = (st_r == ATC_IDLE);
  assign rsp_valid_o          = (st_r == ATC_DONE);
  assign rsp_data_o           = dat_r;
  assign rsp_entry_ok_o       = ok_r;
  assign fetch_req_o          = (st_r == ATC_FETCH);
  assign fetch_page_o         = page_r;
  assign gwb_flush_o          = flush_r;
  assign tlb_enable_o         = tlb_en_r;
  assign fast_rate_override_o = ovr_r;
  assign data_rate_o          = rate_r;
  assign ap_base_b25_o        = b25_r & aperture_size_bit_r;

endmodule // atc_top

/* File: atc_top_properties.sv */
// Checker for the aperture translation control ports.
// Assumes it is bound to atc_top from the bench top file.
`include "atc_map.svh"
module atc_checker
  import atc_pkg::*;
#(
  parameter int TAG_W  = 20,
  parameter int DATA_W = 32
)
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  // Configuration access
  input atc_cfg_type            cfg_i,
  input wire logic [31:0]       cfg_rdata_o,
  // Lookup and fetch
  input wire logic              lk_valid_i,
  input wire logic              lk_ready_o,
  input wire logic              rsp_valid_o,
  input wire logic [DATA_W-1:0] rsp_data_o,
  input wire logic              rsp_entry_ok_o,
  input wire logic              fetch_req_o,
  input wire logic [TAG_W-1:0]  fetch_page_o,
  input wire logic              fetch_ack_i,
  input wire logic [DATA_W-1:0] fetch_data_i,
  input wire logic              fetch_entry_ok_i,
  // Control levels
  input wire logic              gwb_flush_o,
  input wire logic              tlb_enable_o,
  input wire logic              fast_rate_override_o,
  input wire logic              ap_base_b25_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ctl; // Write reaching the control byte
  logic wr_sz;  // Write reaching the size byte
  logic rd_ctl; // Read of the control register
  logic rd_st;  // Read of the port status register
  assign wr_ctl = cfg_i.valid && cfg_i.write && cfg_i.be[0]
                  && cfg_i.addr == `ATC_OFS_CTRL;
  assign wr_sz  = cfg_i.valid && cfg_i.write && cfg_i.be[0]
                  && cfg_i.addr == `ATC_OFS_APERTURE_SIZE_SELECT;
  assign rd_ctl = cfg_i.valid && !cfg_i.write && cfg_i.addr == `ATC_OFS_CTRL;
  assign rd_st  = cfg_i.valid && !cfg_i.write
                  && cfg_i.addr == `ATC_OFS_PORT_STATUS;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_flush_on_write: assert property (
    wr_ctl |=> gwb_flush_o)
    else $error("no write buffer flush after enable write");
  a_flush_has_cause: assert property (
    gwb_flush_o |-> $past(wr_ctl))
    else $error("flush without enable write");
  a_enable_follows: assert property (
    wr_ctl |=> tlb_enable_o == $past(cfg_i.wdata[7]))
    else $error("enable level differs from written bit");
  a_override_follows: assert property (
    wr_ctl |=> fast_rate_override_o == $past(cfg_i.wdata[0]))
    else $error("override level differs from written bit");
  a_rate_hidden: assert property (
    rd_st && fast_rate_override_o |=> !cfg_rdata_o[2])
    else $error("top rate bit visible under override");
  a_rsv_zero: assert property (
    rd_ctl |=> cfg_rdata_o[31:8] == 0 && cfg_rdata_o[6:1] == 0)
    else $error("reserved control bits not zero");
  a_base_gated: assert property (
    wr_sz && !cfg_i.wdata[3] |=> !ap_base_b25_o [*2])
    else $error("base bit 25 set with 64 MB aperture");
  a_off_fetches: assert property (
    lk_valid_i && lk_ready_o && !tlb_enable_o |=> fetch_req_o)
    else $error("disabled lookup did not fetch");
  a_fetch_holds: assert property (
    fetch_req_o && !fetch_ack_i
    |=> fetch_req_o && $stable(fetch_page_o))
    else $error("fetch request dropped or page moved");
  a_ack_answer: assert property (
    fetch_req_o && fetch_ack_i
    |=> rsp_valid_o && rsp_data_o == $past(fetch_data_i)
        && rsp_entry_ok_o == $past(fetch_entry_ok_i))
    else $error("answer differs from fetched entry");

  c_flush: cover property (gwb_flush_o);
  c_fetch_on: cover property (fetch_req_o && fetch_ack_i && tlb_enable_o);
  c_bad_entry: cover property (rsp_valid_o && !rsp_entry_ok_o);
endmodule // atc_checker

/* File: atc_mem_model.sv */
// Memory side model: answers table fetches after a chosen wait.
// Assumes the fetch handshake of atc_top.
module atc_mem_model
#(
  parameter int TAG_W  = 20,
  parameter int DATA_W = 32
)
(
  // Clock, reset and wait length
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [3:0]        delay_i,
  // Fetch handshake
  input  wire logic              req_i,
  input  wire logic [TAG_W-1:0]  page_i,
  output logic                   ack_o,
  output logic      [DATA_W-1:0] data_o,
  output logic                   ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]        wait_r; // Cycles waited so far
  logic [DATA_W-1:0] ent;    // Entry of the requested page
  assign ent = {~page_i[15:0], page_i[15:0]};
  // Data is only good with the ack; inverted otherwise
  assign data_o = ack_o ? ent : ~ent;
  // Odd pages hold entries marked invalid
  assign ok_o = ack_o ? ~page_i[0] : page_i[0];
  // One-cycle ack after the wait
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !req_i || ack_o)
    begin
      ack_o  <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (wait_r >= delay_i)
      ack_o <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
endmodule // atc_mem_model

/* File: test_aperture_translation_control.sv */
// Self-checking bench for the aperture translation control block.
// Assumes atc_top, its checker and the memory side model.
`include "atc_map.svh"
module test_aperture_translation_control
  import atc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_n_i = 0, lk_valid_i = 0;
  atc_cfg_type cfg_i = '0;
  logic [19:0] lk_page_i = 0, fetch_page_o;
  logic [31:0] cfg_rdata_o, rsp_data_o, fetch_data_i, rd;
  logic [2:0]  data_rate_o;
  logic [3:0]  delay = 0;
  logic        lk_ready_o, rsp_valid_o, rsp_entry_ok_o, fetch_req_o;
  logic        fetch_ack_i, fetch_entry_ok_i, gwb_flush_o, tlb_enable_o;
  logic        fast_rate_override_o, ap_base_b25_o;
  int          miscompares = 0, total_checks = 0;

  always #2.5 clk_i = ~clk_i;

  atc_top #(.ENTRIES(4), .TAG_W(20), .DATA_W(32)) uut (.clk_i, .rst_n_i,
    .cfg_i, .cfg_rdata_o, .lk_valid_i, .lk_page_i, .lk_ready_o,
    .rsp_valid_o, .rsp_data_o, .rsp_entry_ok_o, .fetch_req_o,
    .fetch_page_o, .fetch_ack_i, .fetch_data_i, .fetch_entry_ok_i,
    .gwb_flush_o, .tlb_enable_o, .fast_rate_override_o, .data_rate_o,
    .ap_base_b25_o);
  atc_mem_model u_mem (.clk_i, .rst_n_i, .delay_i(delay),
    .req_i(fetch_req_o), .page_i(fetch_page_o), .ack_o(fetch_ack_i),
    .data_o(fetch_data_i), .ok_o(fetch_entry_ok_i));

  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge clk_i) cfg_i <= '{1'b1, 1'b1, a, be, d};
    @(posedge clk_i) cfg_i.valid <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i) cfg_i <= '{1'b1, 1'b0, a, 4'hF, 32'h0000_0000};
    @(posedge clk_i) cfg_i.valid <= 1'b0;
    #1 d = cfg_rdata_o;
  endtask

  // One lookup; fx says whether a table fetch is expected
  task automatic look(input logic [19:0] p, input logic fx);
    logic seen;
    int   n;
    seen = 0;
    n = 0;
    @(posedge clk_i) lk_valid_i <= 1'b1;
    lk_page_i <= p;
    @(posedge clk_i) lk_valid_i <= 1'b0;
    #1 chk(lk_ready_o, 0, "ready while busy");
    do
    begin
      #1 seen = seen | (fetch_req_o === 1'b1);
      if (fetch_req_o === 1'b1)
        chk(fetch_page_o, p, "fetch page");
      n++;
      if (rsp_valid_o !== 1'b1) @(posedge clk_i);
    end while (rsp_valid_o !== 1'b1 && n < 50);
    chk(rsp_valid_o, 1, "answer");
    chk(rsp_data_o, {~p[15:0], p[15:0]}, "entry data");
    chk(rsp_entry_ok_o, !p[0], "entry flag");
    chk(seen, fx, "fetch use");
  endtask

  task automatic t_reset;
    rdr(`ATC_OFS_CTRL, rd); chk(rd, 0, "ctrl reset");
    rdr(`ATC_OFS_APERTURE_SIZE_SELECT, rd); chk(rd, 0, "size reset");
  endtask

  task automatic t_reserved;
    wr(`ATC_OFS_CTRL, 4'hF, 32'hFFFF_FFFF);
    rdr(`ATC_OFS_CTRL, rd); chk(rd, 32'h0000_0081, "ctrl rsv");
    wr(`ATC_OFS_CTRL, 4'hF, 32'h0000_0000);
    wr(`ATC_OFS_APERTURE_SIZE_SELECT, 4'h1, 32'h0000_00FF);
    rdr(`ATC_OFS_APERTURE_SIZE_SELECT, rd); chk(rd, 32'h0000_0008, "size rsv");
  endtask

  task automatic t_aperture;
    wr(`ATC_OFS_AP_BASE, 4'hF, 32'h0200_0000);
    rdr(`ATC_OFS_AP_BASE, rd); chk(rd[25], 1, "base 32MB");
    wr(`ATC_OFS_APERTURE_SIZE_SELECT, 4'h1, 32'h0000_0000);
    rdr(`ATC_OFS_AP_BASE, rd); chk(rd[25], 0, "base 64MB");
    wr(`ATC_OFS_AP_BASE, 4'hF, 32'h0200_0000);
    rdr(`ATC_OFS_AP_BASE, rd); chk(rd[25], 0, "base locked");
  endtask

  task automatic t_rate;
    wr(`ATC_OFS_PORT_STATUS, 4'h1, 32'h0000_0004);
    rdr(`ATC_OFS_PORT_STATUS, rd); chk(rd[2:0], 4, "rate");
    // Firmware on a 3.3 V board hides the fast mode
    wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0001);
    rdr(`ATC_OFS_PORT_STATUS, rd); chk(rd[2:0], 0, "hidden");
    wr(`ATC_OFS_PORT_STATUS, 4'h1, 32'h0000_0002);
    rdr(`ATC_OFS_PORT_STATUS, rd); chk(rd[2:0], 2, "masked");
    chk(data_rate_o, 6, "stored rate");
    wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0000);
    rdr(`ATC_OFS_PORT_STATUS, rd); chk(rd[2:0], 6, "kept");
  endtask

  task automatic t_tlb;
    look(5, 1); look(5, 1);
    wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0080);
    look(6, 1); look(6, 0);
    delay <= 3;
    look(9, 1); look(9, 0);
    wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0000);
    wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0080);
    look(6, 1);
  endtask

  task automatic t_dynamic;
    delay <= 6;
    fork
      look(12, 1);
      begin
        repeat (3) @(posedge clk_i);
        wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0000);
      end
    join
    look(12, 1);
    fork
      look(14, 1);
      begin
        repeat (3) @(posedge clk_i);
        wr(`ATC_OFS_CTRL, 4'h1, 32'h0000_0080);
      end
    join
    look(14, 0);
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_reserved;
    t_aperture;
    t_rate;
    t_tlb;
    t_dynamic;
    test_done;
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    $display("Error %0t watchdog expired", $time);
    test_done;
  end
endmodule // test_aperture_translation_control

bind atc_top atc_checker #(.TAG_W(TAG_W), .DATA_W(DATA_W)) u_chk (.clk_i,
  .rst_n_i, .cfg_i, .cfg_rdata_o, .lk_valid_i, .lk_ready_o, .rsp_valid_o,
  .rsp_data_o, .rsp_entry_ok_o, .fetch_req_o, .fetch_page_o, .fetch_ack_i,
  .fetch_data_i, .fetch_entry_ok_i, .gwb_flush_o, .tlb_enable_o,
  .fast_rate_override_o, .ap_base_b25_o);
